// >>> adr_pkg.sv
// Constants and types for the alarm drive recorder.
// Assumes one 200 MHz clock and a synchronous active-high reset.
package adr_pkg;
	localparam int          NUM_RECORDS   = 16;
	localparam int          NUM_ANALOG    = 7;
	localparam int          ANALOG_W      = 16;
	localparam int          PRE_SAMPLES   = 4;
	localparam int          POST_SAMPLES  = 4;
	localparam int          ALARM_W       = 12;
	localparam int          NUM_EXCLUDED  = 13;
	localparam int          HOLDOFF_W     = 16;
	localparam logic [15:0] TRIG_ANY      = 16'h0000;
	localparam logic [15:0] HOLDOFF_OFF   = 16'h0001;
	localparam int          CLK_MHZ       = 200;
	localparam int          HOLDOFF_US    = 1;
	localparam int          CYC_PER_UNIT  = HOLDOFF_US * CLK_MHZ;
	localparam logic [11:0] EXCLUDED [13] = '{
		12'h101, 12'h120, 12'h150, 12'h160, 12'h170, 12'h190, 12'h1A0,
		12'h1E0, 12'h1F0, 12'h250, 12'h370, 12'h700, 12'h888};
	localparam logic [11:0] OWN_SETS [12] = '{
		12'h100, 12'h200, 12'h210, 12'h240, 12'h300, 12'h310, 12'h320,
		12'h330, 12'h350, 12'h420, 12'h460, 12'h500};
	localparam int          SAMPLES       = PRE_SAMPLES + POST_SAMPLES;
	localparam int          SMP_W         = NUM_ANALOG * ANALOG_W + 8;
	typedef enum logic [1:0] {ADR_IDLE, ADR_POST} adr_state_t;
endpackage : adr_pkg

// >>> adr_recorder.sv
// Alarm-triggered trace recorder with a sixteen-record history.
// Assumes alarm code strobes and sample inputs are synchronous to I_SYS_CLK.
// What this block does
// - No recording while the setup tool graph function is active.
// - No recording while the machine analyzer runs.
// - Recorder stays inactive while the hold-off parameter equals one.
// - No host connected blocks recording, except in test operation.
// - Legacy compatibility mode disables the recorder.
// - Excluded alarm codes never start a record.
// - After graph ends, re-enable once hold-off time elapses or reset.
// - Each record holds samples before and after the alarm instant.
// - Sixteen records kept; a new one overwrites the oldest.
// - Trigger select zero records every non-excluded alarm.
// - Trigger select naming an alarm records only that alarm.
// - Trigger select zero captures the standard channel set.
// - Selected alarm with its own set captures that set.
// - Selected alarm without its own set captures the standard set.
// - A record cut by power loss need not be valid.
// - Some alarms may fail to store, depending on conditions.
// - Torque channel is in 0.1 percent of rated torque.
`timescale 1ns/1ps
module adr_recorder #(
	parameter int NUM_RECORDS  = adr_pkg::NUM_RECORDS,
	parameter int PRE_SAMPLES  = adr_pkg::PRE_SAMPLES,
	parameter int POST_SAMPLES = adr_pkg::POST_SAMPLES
) (
	input  wire logic                       I_SYS_CLK,
	input  wire logic                       I_SYS_RST,
	input  wire logic                       I_SAMPLE_STB,
	input  wire logic [adr_pkg::NUM_ANALOG*adr_pkg::ANALOG_W-1:0] I_ANALOG,
	input  wire logic [adr_pkg::NUM_ANALOG*adr_pkg::ANALOG_W-1:0] I_ALT_ANALOG,
	input  wire logic                       I_SERVO_ON_STATE,
	input  wire logic                       I_EMERGENCY_STOP_INPUT,
	input  wire logic                       I_ALARM_OUTPUT_STATE,
	input  wire logic                       I_IN_POSITION_FLAG,
	input  wire logic                       I_BRAKE_INTERLOCK_OUT,
	input  wire logic                       I_READY_STATE,
	input  wire logic                       I_SAFE_TORQUE_OFF_STATE,
	input  wire logic                       I_POWER_FAIL_FLAG,
	input  wire logic                       I_ALARM_STB,
	input  wire logic [adr_pkg::ALARM_W-1:0] I_ALARM_CODE,
	input  wire logic [15:0]                I_TRIGGER_ALARM_SELECT,
	input  wire logic [15:0]                I_RECORDER_HOLDOFF_PARAM,
	input  wire logic                       I_GRAPH_ACTIVE,
	input  wire logic                       I_ANALYZER_ACTIVE,
	input  wire logic                       I_HOST_CONNECTED,
	input  wire logic                       I_TEST_MODE,
	input  wire logic                       I_LEGACY_MODE,
	input  wire logic                       I_RD_REQ,
	input  wire logic [3:0]                 I_RD_REC,
	input  wire logic [2:0]                 I_RD_SMP,
	output logic                            O_RD_VALID,
	output logic [adr_pkg::SMP_W-1:0]       O_RD_DATA,
	output logic [adr_pkg::ALARM_W-1:0]     O_RD_ALARM,
	output logic                            O_RD_OWN_SET,
	output logic                            O_RECORDING,
	output logic                            O_ENABLED,
	output logic [4:0]                      O_REC_COUNT
);
	localparam int SAMPLES = PRE_SAMPLES + POST_SAMPLES;
	localparam int SW      = adr_pkg::SMP_W;

	initial begin
		if (NUM_RECORDS != 16 || SAMPLES != 8 || PRE_SAMPLES < 1)
			$error("adr_recorder: unsupported record geometry");
	end

	typedef struct packed {
		adr_pkg::adr_state_t         st;
		logic [2:0]                  pre_wr;
		logic [2:0]                  post_cnt;
		logic [3:0]                  wr_rec;
		logic [4:0]                  count;
		logic                        holdoff;
		logic                        graph_was;
		logic [adr_pkg::HOLDOFF_W-1:0] ho_units;
		logic [15:0]                 ho_cyc;
		logic                        rd_valid;
		logic [SW-1:0]               rd_data;
		logic [adr_pkg::ALARM_W-1:0] rd_alarm;
		logic                        rd_own;
		logic                        enabled;
		logic [adr_pkg::ALARM_W-1:0] cur_alarm;
		logic                        cur_own;
	} adr_regs_t;

	adr_regs_t r_q;
	adr_regs_t r_d;

	// Sample history lives in a plain array so it maps onto block RAM
	logic [SW-1:0]               ring_q [SAMPLES];
	logic [SW-1:0]               mem_q  [NUM_RECORDS*SAMPLES];
	logic [adr_pkg::ALARM_W-1:0] alm_q  [NUM_RECORDS];
	logic                        own_q  [NUM_RECORDS];

	logic [SW-1:0] sample;
	logic          excluded;
	logic          has_own;
	logic          trig;
	logic          use_own;

	// Status bits in fixed order, torque channel already in 0.1 percent
	assign sample = {use_own ? I_ALT_ANALOG : I_ANALOG,
		I_SERVO_ON_STATE, I_EMERGENCY_STOP_INPUT, I_ALARM_OUTPUT_STATE,
		I_IN_POSITION_FLAG, I_BRAKE_INTERLOCK_OUT, I_READY_STATE,
		I_SAFE_TORQUE_OFF_STATE, I_POWER_FAIL_FLAG};

	// Code lookups against the fixed tables
	always_comb begin
		excluded = 1'b0;
		has_own  = 1'b0;
		for (int i = 0; i < adr_pkg::NUM_EXCLUDED; i++) begin
			if (I_ALARM_CODE == adr_pkg::EXCLUDED[i])
				excluded = 1'b1;
		end
		for (int i = 0; i < 12; i++) begin
			if (I_TRIGGER_ALARM_SELECT[11:0] == adr_pkg::OWN_SETS[i])
				has_own = 1'b1;
		end
	end

	// Standard set unless a selected alarm owns a set
	assign use_own = (I_TRIGGER_ALARM_SELECT != adr_pkg::TRIG_ANY)
		&& has_own;

	// Alarm qualifies only when recorder enabled and the selection matches
	assign trig = I_ALARM_STB && !excluded && r_q.enabled
		&& r_q.st == adr_pkg::ADR_IDLE
		&& (I_TRIGGER_ALARM_SELECT == adr_pkg::TRIG_ANY
		|| I_TRIGGER_ALARM_SELECT[11:0] == I_ALARM_CODE);

	// Next-state logic for all control state
	always_comb begin
		r_d = r_q;
		r_d.rd_valid = 1'b0;
		// Gate conditions; hold-off timer runs after graph ends
		r_d.graph_was = I_GRAPH_ACTIVE;
		if (r_q.graph_was && !I_GRAPH_ACTIVE) begin
			r_d.holdoff  = 1'b1;
			r_d.ho_units = I_RECORDER_HOLDOFF_PARAM;
			r_d.ho_cyc   = 16'h0000;
		end else if (r_q.holdoff) begin
			if (r_q.ho_units == '0) begin
				r_d.holdoff = 1'b0;
			end else if (r_q.ho_cyc == 16'(adr_pkg::CYC_PER_UNIT - 1)) begin
				r_d.ho_cyc   = 16'h0000;
				r_d.ho_units = r_q.ho_units - 1'b1;
			end else begin
				r_d.ho_cyc = r_q.ho_cyc + 16'h0001;
			end
		end
		r_d.enabled = !I_GRAPH_ACTIVE
			&& !I_ANALYZER_ACTIVE
			&& I_RECORDER_HOLDOFF_PARAM != adr_pkg::HOLDOFF_OFF
			&& (I_HOST_CONNECTED || I_TEST_MODE)
			&& !I_LEGACY_MODE
			&& !r_d.holdoff;
		// Pre-alarm ring advances every sample while idle
		unique case (r_q.st)
			adr_pkg::ADR_IDLE: begin
				if (I_SAMPLE_STB)
					r_d.pre_wr = r_q.pre_wr + 3'h1;
				if (trig) begin
					r_d.st        = adr_pkg::ADR_POST;
					r_d.post_cnt  = 3'h0;
					r_d.cur_alarm = I_ALARM_CODE;
					r_d.cur_own   = use_own;
				end
			end
			adr_pkg::ADR_POST: begin
				if (I_SAMPLE_STB) begin
					r_d.post_cnt = r_q.post_cnt + 3'h1;
					if (r_q.post_cnt == 3'(POST_SAMPLES - 1)) begin
						r_d.st     = adr_pkg::ADR_IDLE;
						r_d.wr_rec = r_q.wr_rec + 4'h1;
						if (r_q.count != 5'(NUM_RECORDS))
							r_d.count = r_q.count + 5'h01;
					end
				end
			end
		endcase
		// Read port returns stored data only
		if (I_RD_REQ && r_q.st == adr_pkg::ADR_IDLE) begin
			r_d.rd_valid = 1'b1;
			r_d.rd_data  = mem_q[{I_RD_REC, I_RD_SMP}];
			r_d.rd_alarm = alm_q[I_RD_REC];
			r_d.rd_own   = own_q[I_RD_REC];
		end
		if (I_SYS_RST) begin
			r_d = '0;
			r_d.st = adr_pkg::ADR_IDLE;
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		r_q <= r_d;
	end

	// Sample storage; pre-alarm ring copied in when the alarm triggers the record
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SAMPLE_STB && r_q.st == adr_pkg::ADR_IDLE)
			ring_q[r_q.pre_wr] <= sample;
		if (trig) begin
			alm_q[r_q.wr_rec] <= I_ALARM_CODE;
			own_q[r_q.wr_rec] <= use_own;
			for (int i = 0; i < PRE_SAMPLES; i++) begin
				mem_q[{r_q.wr_rec, 3'(i)}] <=
					ring_q[3'(r_q.pre_wr - 3'(PRE_SAMPLES) + 3'(i))];
			end
		end
		// Power loss mid-store simply leaves a partial record
		if (I_SAMPLE_STB && r_q.st == adr_pkg::ADR_POST)
			mem_q[{r_q.wr_rec, 3'(PRE_SAMPLES + 32'(r_q.post_cnt))}]
				<= sample;
	end

	assign O_RD_VALID   = r_q.rd_valid;
	assign O_RD_DATA    = r_q.rd_data;
	assign O_RD_ALARM   = r_q.rd_alarm;
	assign O_RD_OWN_SET = r_q.rd_own;
	assign O_RECORDING  = r_q.st == adr_pkg::ADR_POST;
	assign O_ENABLED    = r_q.enabled;
	assign O_REC_COUNT  = r_q.count;
endmodule : adr_recorder

// >>> adr_recorder_asserts.sv
// Checker for the recorder top ports.
// Assumes one clock domain and the bind at the foot.
`timescale 1ns/1ps
module adr_recorder_asserts (
	input wire logic        I_SYS_CLK,
	input wire logic        I_SYS_RST,
	input wire logic        I_ALARM_STB,
	input wire logic [11:0] I_ALARM_CODE,
	input wire logic [15:0] I_TRIGGER_ALARM_SELECT,
	input wire logic [15:0] I_RECORDER_HOLDOFF_PARAM,
	input wire logic        I_GRAPH_ACTIVE,
	input wire logic        I_ANALYZER_ACTIVE,
	input wire logic        I_HOST_CONNECTED,
	input wire logic        I_TEST_MODE,
	input wire logic        I_LEGACY_MODE,
	input wire logic        I_RD_REQ,
	input wire logic        O_RD_VALID,
	input wire logic        O_RD_OWN_SET,
	input wire logic        O_RECORDING,
	input wire logic        O_ENABLED,
	input wire logic [4:0]  O_REC_COUNT
);
	logic go, ex, hit;
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (I_SYS_RST);
	// Trigger terms; two-cycle hold covers the enable lag
	assign ex  = I_ALARM_CODE inside {adr_pkg::EXCLUDED};
	assign hit = I_TRIGGER_ALARM_SELECT == 16'h0000 ||
		I_TRIGGER_ALARM_SELECT[11:0] == I_ALARM_CODE;
	assign go  = I_ALARM_STB && O_ENABLED && !O_RECORDING;
	graph_off_a: assert property (I_GRAPH_ACTIVE [*2] |=> !O_ENABLED)
		else $error("enabled during graph");
	analyzer_off_a: assert property (I_ANALYZER_ACTIVE [*2] |=> !O_ENABLED)
		else $error("enabled during analyzer");
	holdoff_off_a: assert property (
		$past(I_RECORDER_HOLDOFF_PARAM) == 16'h0001
		&& I_RECORDER_HOLDOFF_PARAM == 16'h0001 |=> !O_ENABLED)
		else $error("enabled with hold-off one");
	no_host_a: assert property (
		(!I_HOST_CONNECTED && !I_TEST_MODE) [*2] |=> !O_ENABLED)
		else $error("enabled without host");
	legacy_off_a: assert property (I_LEGACY_MODE [*2] |=> !O_ENABLED)
		else $error("enabled in legacy mode");
	excl_alarm_a: assert property (go && ex |=> !O_RECORDING)
		else $error("excluded alarm recorded");
	trig_start_a: assert property (go && !ex && hit |=> O_RECORDING)
		else $error("alarm not recorded");
	sel_miss_a: assert property (
		I_ALARM_STB && !O_RECORDING && !hit |=> !O_RECORDING)
		else $error("unselected alarm recorded");
	rd_answer_a: assert property (I_RD_REQ && !O_RECORDING |=> O_RD_VALID)
		else $error("read not answered");
	count_cap_a: assert property (O_REC_COUNT <= 5'h10)
		else $error("record count above sixteen");
	cover property (go && !ex && hit);
	cover property ($fell(O_RECORDING));
	cover property (O_RD_VALID && O_RD_OWN_SET);
endmodule : adr_recorder_asserts
bind adr_recorder adr_recorder_asserts u_chk (.*);

// >>> adr_host.sv
// Host model reading stored records one sample at a time.
// Assumes read answers one cycle after the request edge.
`timescale 1ns/1ps
module adr_host (
	input  wire logic         i_clk,
	input  wire logic         i_rec,
	input  wire logic [119:0] i_dat,
	output logic              o_req,
	output logic [3:0]        o_rec,
	output logic [2:0]        o_smp
);
	initial {o_req, o_rec, o_smp} = 8'h00;
	// Waits out a capture, since reads are refused then
	task automatic rd(input logic [3:0] r, input logic [2:0] s,
		output logic [119:0] d);
		@(posedge i_clk);
		while (i_rec) @(posedge i_clk);
		o_req <= 1'b1;
		o_rec <= r;
		o_smp <= s;
		@(posedge i_clk);
		o_req <= 1'b0;
		#1 d = i_dat;
	endtask : rd
endmodule : adr_host

// >>> test_alarm_drive_recorder.sv
// Self-checking bench for the alarm drive recorder.
// Assumes read slots are filled in write order from zero.
`timescale 1ns/1ps
module test_alarm_drive_recorder;
	localparam logic [4:0] CFV [6] = '{5'h14, 5'h0C, 5'h00, 5'h02, 5'h05, 5'h04};
	logic         clk = 0, rst = 1, stb = 0, ast = 0, vld, rec, en, own, req;
	logic [111:0] ana = 0, alt = 0;
	logic [127:0] r;
	logic [119:0] dat, d, qa[$], qb[$];
	logic [15:0]  sel = 0, hold = 0;
	logic [11:0]  code = 0, ral;
	logic [7:0]   st = 0;
	logic [4:0]   cf = 5'h04, cnt;
	logic [3:0]   rr;
	logic [2:0]   rs;
	int           seed = 32'hb0e4, failures = 0, checks = 0, cyc = 0, i;
	initial forever #2.5 clk = ~clk;
	adr_recorder i_dut (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_SAMPLE_STB(stb),
		.I_ANALOG(ana), .I_ALT_ANALOG(alt), .I_SERVO_ON_STATE(st[7]),
		.I_EMERGENCY_STOP_INPUT(st[6]), .I_ALARM_OUTPUT_STATE(st[5]),
		.I_IN_POSITION_FLAG(st[4]), .I_BRAKE_INTERLOCK_OUT(st[3]),
		.I_READY_STATE(st[2]), .I_SAFE_TORQUE_OFF_STATE(st[1]),
		.I_POWER_FAIL_FLAG(st[0]), .I_ALARM_STB(ast), .I_ALARM_CODE(code),
		.I_TRIGGER_ALARM_SELECT(sel), .I_RECORDER_HOLDOFF_PARAM(hold),
		.I_GRAPH_ACTIVE(cf[4]), .I_ANALYZER_ACTIVE(cf[3]),
		.I_HOST_CONNECTED(cf[2]), .I_TEST_MODE(cf[1]), .I_LEGACY_MODE(cf[0]),
		.I_RD_REQ(req), .I_RD_REC(rr), .I_RD_SMP(rs), .O_RD_VALID(vld),
		.O_RD_DATA(dat), .O_RD_ALARM(ral), .O_RD_OWN_SET(own),
		.O_RECORDING(rec), .O_ENABLED(en), .O_REC_COUNT(cnt));
	adr_host h (.i_clk(clk), .i_rec(rec), .i_dat(dat), .o_req(req),
		.o_rec(rr), .o_smp(rs));
	task automatic chk(input string n, input logic [119:0] g, e);
		checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	// Expected sample k of the newest record
	function automatic logic [119:0] exp_smp(input int k, input bit o);
		return o ? qb[qb.size() - 8 + k] : qa[qa.size() - 8 + k];
	endfunction : exp_smp
	// Random channels; status byte rides both sets
	task automatic smp(input int n);
		repeat (n) begin
			@(posedge clk);
			r = {$random(seed), $random(seed), $random(seed), $random(seed)};
			ana <= r[111:0];
			alt <= r[127:16];
			st <= r[7:0];
			stb <= 1'b1;
			qa.push_back({r[111:0], r[7:0]});
			qb.push_back({r[127:16], r[7:0]});
			@(posedge clk);
			stb <= 1'b0;
		end
	endtask : smp
	task automatic alarm(input logic [11:0] c, input logic e);
		@(posedge clk);
		code <= c;
		ast <= 1'b1;
		@(posedge clk);
		ast <= 1'b0;
		#1 chk("recording", rec, e);
	endtask : alarm
	task automatic record(input logic [11:0] c, input logic e);
		smp(4);
		alarm(c, e);
		smp(4);
		repeat (2) @(posedge clk);
		#1 chk("recording done", rec, 0);
	endtask : record
	// Reads a whole record, pre samples oldest first
	task automatic rd_rec(input logic [3:0] s, input bit o, input logic [11:0] c);
		for (int k = 0; k < 8; k++) begin
			h.rd(s, k, d);
			chk("valid", vld, 1);
			chk("sample", d, exp_smp(k, o));
		end
		chk("alarm code", ral, c);
		chk("own set", own, o);
	endtask : rd_rec
	task automatic final_report;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : final_report
	// Cycle ceiling far above the expected run
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			final_report;
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 0;
		for (i = 0; i < 6; i++) begin
			cf <= CFV[i];
			repeat (4) @(posedge clk);
			chk("enable", en, i == 3 || i == 5);
		end
		hold <= 16'h0001;
		repeat (4) @(posedge clk);
		chk("enable hold one", en, 0);
		hold <= 16'h0002;
		cf <= 5'h14;
		repeat (4) @(posedge clk);
		cf <= 5'h04;
		repeat (200) @(posedge clk);
		chk("hold-off wait", en, 0);
		repeat (300) @(posedge clk);
		chk("hold-off done", en, 1);
		hold <= 16'h0000;
		for (i = 0; i < adr_pkg::NUM_EXCLUDED; i++)
			alarm(adr_pkg::EXCLUDED[i], 0);
		chk("count", cnt, 0);
		for (i = 0; i < 17; i++) record(12'h300 + i, 1);
		chk("count full", cnt, 16);
		rd_rec(0, 0, 12'h310);
		sel <= 16'h0200;
		record(12'h210, 0);
		record(12'h200, 1);
		rd_rec(1, 1, 12'h200);
		sel <= 16'h0450;
		record(12'h450, 1);
		rd_rec(2, 0, 12'h450);
		final_report;
	end
endmodule : test_alarm_drive_recorder
